// file: basic_mode_status_defs.vh
// Purpose: Constants for the basic mode status register.
// Assumes: Management register addresses are 5 bits wide.
// Notes: Included by both design files.
`ifndef BASIC_MODE_STATUS_DEFS_VH
`define BASIC_MODE_STATUS_DEFS_VH
`define BMS_ADDR 5'h01
`define BMS_BIT_FAST_FD 14
`define BMS_BIT_FAST_HD 13
`define BMS_BIT_TEN_FD 12
`define BMS_BIT_TEN_HD 11
`define BMS_BIT_EXTENDED_STATUS_PRESENT 8
`define BMS_BIT_NO_PRE 6
`define BMS_BIT_NEG_DONE 5
`define BMS_BIT_REM_FAULT 4
`define BMS_BIT_NEG_ABLE 3
`define BMS_BIT_LINK 2
`define BMS_BIT_EXT_REG 0
`define BMS_FIXED_ONES 16'h7949
`define BMS_FAULT_RESET 1'b0
`define BMS_LINK_RESET 1'b0
`define BMS_PARTNER_FAULT_LO 12
`define BMS_PARTNER_FAULT_HI 13
`endif

// file: fault_detect.v
// Purpose: Combines the remote fault sources for the selected serial mode.
// Assumes: All inputs are synchronous to mclk.
// Notes: Output is registered so the status block sees a clean level.
`timescale 1ns/1ps
`include "basic_mode_status_defs.vh"
module fault_detect (
  input wire mclk,
  input wire sys_rst,
  input wire sgmiiMode,
  input wire lossOfSignalInput,
  input wire cdrLossOfLock,
  input wire [15:0] partnerAbilityWord,
  output reg faultPresent_ff
);
  wire [1:0] partnerFaultField;
  wire nxt_faultPresent;
  assign partnerFaultField =
    partnerAbilityWord[`BMS_PARTNER_FAULT_HI:`BMS_PARTNER_FAULT_LO];
  assign nxt_faultPresent = sgmiiMode ? (lossOfSignalInput | cdrLossOfLock)
                                      : (partnerFaultField != 2'h0);
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      faultPresent_ff <= 1'b0;
    end else begin
      faultPresent_ff <= nxt_faultPresent;
    end
  end
endmodule // fault_detect

// file: basic_mode_status_register.v
// Purpose: Read-only basic mode status register at management address 1.
// Assumes: Management access arrives as a read or write strobe with a 5-bit address.
// Notes: Latched flags update on the same edge that captures the read data, which holds their pre-read values.
//
// Contract
// - Bits 14 to 11 always read 1, advertising four speed/duplex abilities.
// - Bit 8 always reads 1: extended status register present.
// - Bit 6 always reads 1: preamble-less management frames accepted.
// - Bit 3 always reads 1: auto-negotiation capable.
// - Bit 0 always reads 1: extended registers implemented.
// - Bit 5 shows negotiation done; 0 while running or inactive.
// - SGMII mode: loss of signal or CDR loss of lock sets remote fault.
// - 1000BASE-X mode: partner fault field nonzero sets remote fault.
// - Remote fault sticks high; a read clears it only if fault absent.
// - Interrupt register gets a read-only copy of remote fault.
// - Link flag latches 0 on link down, held until read finds link up.
// - A read sets link flag to 1 if PCS is link-up, else unchanged.
// - Interrupt register gets a read-only copy of the link flag.
// - Writes to this register are ignored.
// - Decoded at address 1 regardless of page select.
`timescale 1ns/1ps
`include "basic_mode_status_defs.vh"
module basic_mode_status_register (
  input wire mclk,
  input wire sys_rst,
  input wire mgmtRead,
  input wire mgmtWrite,
  input wire [4:0] mgmtAddr,
  input wire [15:0] mgmtWriteData,
  input wire sgmiiMode,
  input wire negotiationDone,
  input wire pcsLinkUp,
  input wire lossOfSignalInput,
  input wire cdrLossOfLock,
  input wire [15:0] partnerAbilityWord,
  output reg [15:0] mgmtReadData_ff,
  output reg mgmtReadValid_ff,
  output reg remoteFaultCopy_ff,
  output reg linkStatusCopy_ff
);
  reg remoteFaultFlag_ff;
  reg linkStatusFlag_ff;
  reg nxt_remoteFaultFlag;
  reg nxt_linkStatusFlag;
  reg [15:0] nxt_readData;
  wire faultPresent;
  wire hit;

  fault_detect faultUnit (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .sgmiiMode(sgmiiMode),
    .lossOfSignalInput(lossOfSignalInput),
    .cdrLossOfLock(cdrLossOfLock),
    .partnerAbilityWord(partnerAbilityWord),
    .faultPresent_ff(faultPresent)
  );

  // Page select is not consulted; the low addresses are never banked.
  assign hit = mgmtRead && (mgmtAddr == `BMS_ADDR);

  function [15:0] compose;
    input fault;
    input link;
    input done;
    begin
      compose = `BMS_FIXED_ONES;
      compose[`BMS_BIT_NEG_DONE] = done;
      compose[`BMS_BIT_REM_FAULT] = fault;
      compose[`BMS_BIT_LINK] = link;
    end
  endfunction

  always @* begin
    nxt_remoteFaultFlag = remoteFaultFlag_ff;
    nxt_linkStatusFlag = linkStatusFlag_ff;
    nxt_readData = compose(remoteFaultFlag_ff, linkStatusFlag_ff, negotiationDone);
    // A live event outranks the read update so a fault or drop is never lost.
    if (hit) begin
      if (!faultPresent) begin
        nxt_remoteFaultFlag = 1'b0;
      end
      if (pcsLinkUp) begin
        nxt_linkStatusFlag = 1'b1;
      end
    end
    if (faultPresent) begin
      nxt_remoteFaultFlag = 1'b1;
    end
    if (!pcsLinkUp) begin
      nxt_linkStatusFlag = 1'b0;
    end
  end

  // Writes carry no effect: mgmtWrite and mgmtWriteData steer nothing here.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      remoteFaultFlag_ff <= `BMS_FAULT_RESET;
      linkStatusFlag_ff <= `BMS_LINK_RESET;
      mgmtReadData_ff <= 16'h0000;
      mgmtReadValid_ff <= 1'b0;
      remoteFaultCopy_ff <= 1'b0;
      linkStatusCopy_ff <= 1'b0;
    end else begin
      remoteFaultFlag_ff <= nxt_remoteFaultFlag;
      linkStatusFlag_ff <= nxt_linkStatusFlag;
      mgmtReadValid_ff <= hit;
      if (hit) begin
        mgmtReadData_ff <= nxt_readData;
      end
      remoteFaultCopy_ff <= nxt_remoteFaultFlag;
      linkStatusCopy_ff <= nxt_linkStatusFlag;
    end
  end
endmodule // basic_mode_status_register

// file: bms_checker.sv
// Purpose: Port checker for the status register.
// Assumes: One clock domain.
// Notes: Bound by name.
`timescale 1ns/1ps
module bms_checker (
  input logic mclk,
  input logic sys_rst,
  input logic mgmtRead,
  input logic sgmiiMode,
  input logic negotiationDone,
  input logic pcsLinkUp,
  input logic lossOfSignalInput,
  input logic cdrLossOfLock,
  input logic mgmtReadValid_ff,
  input logic remoteFaultCopy_ff,
  input logic linkStatusCopy_ff,
  input logic [4:0] mgmtAddr,
  input logic [15:0] partnerAbilityWord,
  input logic [15:0] mgmtReadData_ff
);
  wire hit = mgmtRead && mgmtAddr == 5'h01;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  fixed_bits_a: assert property (
    mgmtReadValid_ff |-> (mgmtReadData_ff & 16'hFFCB) == 16'h7949) else $error("fixed");
  read_answer_a: assert property (
    mgmtReadValid_ff == $past(hit)) else $error("valid");
  pre_read_a: assert property (hit |=> mgmtReadData_ff[5:2] ==
    {$past(negotiationDone), $past(remoteFaultCopy_ff), 1'b1, $past(linkStatusCopy_ff)})
    else $error("flags");
  link_drop_a: assert property (!pcsLinkUp |=> !linkStatusCopy_ff) else $error("drop");
  link_set_a: assert property ($rose(linkStatusCopy_ff) |-> $past(hit && pcsLinkUp))
    else $error("set");
  fault_clear_a: assert property ($fell(remoteFaultCopy_ff) |-> $past(hit))
    else $error("clear");
  sgmii_fault_a: assert property (sgmiiMode && (lossOfSignalInput || cdrLossOfLock)
    |-> ##2 remoteFaultCopy_ff) else $error("sgmii");
  partner_fault_a: assert property (!sgmiiMode && partnerAbilityWord[13:12] != 2'h0
    |-> ##2 remoteFaultCopy_ff) else $error("partner");
endmodule // bms_checker
bind basic_mode_status_register bms_checker i_bms_checker (
  .mclk(mclk),
  .sys_rst(sys_rst),
  .mgmtRead(mgmtRead),
  .sgmiiMode(sgmiiMode),
  .negotiationDone(negotiationDone),
  .pcsLinkUp(pcsLinkUp),
  .lossOfSignalInput(lossOfSignalInput),
  .cdrLossOfLock(cdrLossOfLock),
  .mgmtReadValid_ff(mgmtReadValid_ff),
  .remoteFaultCopy_ff(remoteFaultCopy_ff),
  .linkStatusCopy_ff(linkStatusCopy_ff),
  .mgmtAddr(mgmtAddr),
  .partnerAbilityWord(partnerAbilityWord),
  .mgmtReadData_ff(mgmtReadData_ff)
);

// file: mgmt_station.sv
// Purpose: Station management model issuing reads.
// Assumes: req changes between edges.
// Notes: One-cycle read strobes, back to back allowed.
`timescale 1ns/1ps
module mgmt_station (
  input wire mclk,
  input wire [5:0] req,
  output logic mgmtRead = 1'b0,
  output logic [4:0] mgmtAddr = 5'h00
);
  always @(posedge mclk) {mgmtRead, mgmtAddr} <= #1 req;
endmodule // mgmt_station

// file: tb_top.sv
// Purpose: Random bench for the status register.
// Assumes: Inputs move 1 ns after each edge.
// Notes: A bench model tracks both latched flags.
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, sys_rst = 1, mgmtWrite = 0, sgmiiMode = 0, negotiationDone = 0, pcsLinkUp = 0;
  logic lossOfSignalInput = 0, cdrLossOfLock = 0, mgmtRead, mgmtReadValid_ff, hitv;
  logic remoteFaultCopy_ff, linkStatusCopy_ff, fSrc = 0, eFault = 0, eLink = 0;
  logic [4:0] mgmtAddr;
  logic [5:0] req = 0;
  logic [15:0] mgmtWriteData = 0, partnerAbilityWord = 0, mgmtReadData_ff, eData = 0;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #2 mclk = ~mclk;
  mgmt_station i_mgmt_station (.mclk, .req, .mgmtRead, .mgmtAddr);
  basic_mode_status_register i_basic_mode_status_register (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .mgmtRead(mgmtRead),
    .mgmtWrite(mgmtWrite),
    .mgmtAddr(mgmtAddr),
    .mgmtWriteData(mgmtWriteData),
    .sgmiiMode(sgmiiMode),
    .negotiationDone(negotiationDone),
    .pcsLinkUp(pcsLinkUp),
    .lossOfSignalInput(lossOfSignalInput),
    .cdrLossOfLock(cdrLossOfLock),
    .partnerAbilityWord(partnerAbilityWord),
    .mgmtReadData_ff(mgmtReadData_ff),
    .mgmtReadValid_ff(mgmtReadValid_ff),
    .remoteFaultCopy_ff(remoteFaultCopy_ff),
    .linkStatusCopy_ff(linkStatusCopy_ff)
  );
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    if (seen !== exp) n_errors++;
  endtask
  task automatic complete_run;
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) n_errors++;
    if (cyc == 4000) complete_run;
  end
  initial begin
    void'($urandom(39));
    repeat (16) @(posedge mclk);
    #1 sys_rst = 0;
    repeat (3000) begin
      @(posedge mclk);
      hitv = mgmtRead && mgmtAddr == 5'h01;
      if (hitv) eData = 16'h7949 | {10'h000, negotiationDone, eFault, 1'b0, eLink, 2'h0};
      eFault = fSrc | (eFault & ~hitv);
      eLink = pcsLinkUp & (eLink | hitv);
      fSrc = sgmiiMode ? lossOfSignalInput | cdrLossOfLock : |partnerAbilityWord[13:12];
      #1 check(mgmtReadData_ff, eData);
      check({14'h0, remoteFaultCopy_ff, linkStatusCopy_ff}, {14'h0, eFault, eLink});
      check({15'h0, mgmtReadValid_ff}, {15'h0, hitv});
      req = {1'($urandom), $urandom % 4 ? 5'h01 : 5'($urandom)};
      {mgmtWrite, mgmtWriteData, sgmiiMode, negotiationDone} = 19'($urandom);
      {pcsLinkUp, lossOfSignalInput} = {$urandom % 8 > 0, $urandom % 16 < 1};
      cdrLossOfLock = $urandom % 16 < 1;
      partnerAbilityWord = 16'($urandom) & ($urandom % 8 ? 16'hCFFF : 16'hFFFF);
    end
    complete_run;
  end
endmodule // tb_top
